// ==== shared/ovf_timer_pkg.sv ====
// Register map, field positions and constants of the 8-bit overflow timer
package ovf_timer_pkg;
    localparam logic [7:0] TIMER_CONTROL_ADDR = 8'h00;
    localparam logic [7:0] COUNTER_VALUE_ADDR = 8'h04;
    localparam logic [7:0] TIMER_IRQ_MASK_ADDR = 8'h08;
    localparam logic [7:0] TIMER_IRQ_FLAGS_ADDR = 8'h0C;
    localparam logic [7:0] PRESCALER_CTRL_ADDR = 8'h10;
    localparam int SEL_LSB = 0;
    localparam int SEL_W = 3;
    localparam int OVF_BIT = 0;
    localparam int PRESC_RESET_BIT = 0;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] COUNTER_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam int PRESC_W = 10;
    localparam logic [2:0] SEL_STOP = 3'h0;
    localparam logic [2:0] SEL_DIV1 = 3'h1;
    localparam logic [2:0] SEL_DIV8 = 3'h2;
    localparam logic [2:0] SEL_DIV64 = 3'h3;
    localparam logic [2:0] SEL_DIV256 = 3'h4;
    localparam logic [2:0] SEL_DIV1024 = 3'h5;
    localparam logic [2:0] SEL_EXT_FALL = 3'h6;
    localparam logic [2:0] SEL_EXT_RISE = 3'h7;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
endpackage

// ==== tb/count_pin_model.sv ====
// Count pin driver: one full pulse per request
`timescale 1ns/1ps
`default_nettype none
module count_pin_model (input wire logic ref_clk, fire, output logic pin = 1'b0);
    logic [2:0] ph = 3'h0;
    always @(posedge ref_clk) begin
        ph <= (ph != 3'h0) ? ph - 3'h1 : (fire ? 3'h4 : 3'h0);
        pin <= ph > 3'h2; // High level held two cycles, low level at least three
    end
endmodule // count_pin_model
`default_nettype wire

// ==== tb/eight_bit_overflow_timer_bench.sv ====
// Bench for the overflow timer
`timescale 1ns/1ps
`default_nettype none
module eight_bit_overflow_timer_bench import ovf_timer_pkg::*;;
    localparam logic [7:0] CT = TIMER_CONTROL_ADDR, CV = COUNTER_VALUE_ADDR;
    localparam logic [7:0] FL = TIMER_IRQ_FLAGS_ADDR;
    logic ref_clk = '0, arst_n = '0, clkEn = '1, psel = '0, penable = '0, pwrite = '0;
    logic fire = '0, globalIrqEnable = '0, overflowIrqAck = '0, pin, pready, pslverr, irqOut, se;
    logic [9:0] taps;
    logic [7:0] paddr = '0, otherFlagSet = '0, counterValue;
    logic [31:0] pwdata = '0, prdata, q;
    int miscompares = 0, cmp_count = 0, n, dv[4] = '{8, 64, 256, 1024};
    eight_bit_overflow_timer eight_bit_overflow_timer_i (.ref_clk(ref_clk), .arst_n(arst_n),
        .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .externalCountPin(pin), .globalIrqEnable(globalIrqEnable),
        .overflowIrqAck(overflowIrqAck), .otherFlagSet(otherFlagSet), .irqOut(irqOut),
        .counterValue(counterValue), .prescalerTaps(taps));
    count_pin_model count_pin_model_i (.ref_clk(ref_clk), .fire(fire), .pin(pin));
    initial forever #5 ref_clk = ~ref_clk;
    task automatic cyc(int k); repeat (k) @(posedge ref_clk); endtask
    task automatic finish_test;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(string s, logic [31:0] e, logic [31:0] v);
        cmp_count++;
        if (v !== e) begin miscompares++; $display("BAD %s exp %h got %h", s, e, v); end
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        logic ok;
        ok = 1'b0;
        n = 0;
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge ref_clk) penable <= 1'b1;
        while (!ok && n < 20) begin
            @(negedge ref_clk) ok = (pready === 1'b1);
            q = prdata;
            se = pslverr;
            @(posedge ref_clk);
            n++;
        end
        if (!ok) begin chk("pready", 1, 0); finish_test(); end
        {psel, penable} <= 2'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e);
        apb(0, a, 0);
        chk($sformatf("reg %h", a), e, q);
    endtask
    task automatic t_hold;
        rd(FL, 0);
        apb(1, CV, 8'h5A); cyc(20);
        rd(CV, 8'h5A);
        chk("pslverr", 0, se);
        rd(8'h14, 0);
        chk("pslverr", 1, se);
        apb(1, PRESCALER_CTRL_ADDR, 1);
        @(negedge ref_clk) chk("taps", 1, taps);
        @(posedge ref_clk);
        apb(1, CT, SEL_DIV1); clkEn <= 0;
        @(negedge ref_clk) q = counterValue;
        repeat (5) @(negedge ref_clk);
        chk("frozen", q, counterValue);
        @(posedge ref_clk) clkEn <= 1;
    endtask
    task automatic t_ovf;
        apb(1, CV, 8'hFE); apb(1, CT, SEL_STOP);
        rd(FL, 1);
        apb(1, TIMER_IRQ_MASK_ADDR, 1);
        chk("irq", 0, irqOut);
        globalIrqEnable <= 1; otherFlagSet <= 8'h04;
        @(posedge ref_clk) otherFlagSet <= 0;
        apb(1, FL, 0);
        chk("irq", 1, irqOut);
        apb(1, FL, 1);
        rd(FL, 8'h04);
        apb(1, CV, 8'hFF); apb(1, CT, SEL_DIV1); apb(1, CT, SEL_STOP);
        chk("irq", 1, irqOut);
        overflowIrqAck <= 1;
        @(posedge ref_clk) overflowIrqAck <= 0;
        rd(FL, 8'h04);
    endtask
    task automatic t_ext(logic [2:0] sel, int k, logic [7:0] e);
        apb(1, CT, sel);
        repeat (k) begin fire <= 1; @(posedge ref_clk) fire <= 0; cyc(6); end
        rd(CV, e);
    endtask
    task automatic t_presc;
        foreach (dv[i]) begin
            apb(1, CV, 0); apb(1, CT, SEL_DIV8 + i); cyc(4 * dv[i]); apb(1, CT, SEL_STOP);
            apb(0, CV, 0);
            chk("ticks", 1, q >= 4 && q <= 5);
        end
    endtask
    initial begin
        cyc(16);
        arst_n <= 1;
        cyc(1);
        t_hold(); t_ovf(); apb(1, CV, 0);
        t_ext(SEL_EXT_RISE, 3, 8'h03); t_ext(SEL_EXT_FALL, 2, 8'h05); t_presc();
        finish_test();
    end
endmodule // eight_bit_overflow_timer_bench
`default_nettype wire

// ==== tb/ovf_timer_monitor.sv ====
// Port checker for the overflow timer
`timescale 1ns/1ps
`default_nettype none
module ovf_timer_monitor import ovf_timer_pkg::*; (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic overflowIrqAck,
    input wire logic irqOut,
    input wire logic globalIrqEnable,
    input wire logic [7:0] paddr,
    input wire logic [7:0] counterValue,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    wire wr = psel && penable && pwrite && clkEn;
    sequence s_cw; wr && paddr == COUNTER_VALUE_ADDR; endsequence
    sequence s_fc; wr && paddr == TIMER_IRQ_FLAGS_ADDR && pwdata[0] ##1 counterValue != 8'h00; endsequence
    property p_gate; !globalIrqEnable |-> !irqOut; endproperty
    a_gate: assert property (p_gate) else $error("gate");
    property p_step; $changed(counterValue) && !$past(wr) |->
        counterValue == $past(counterValue) + 8'h01; endproperty
    a_step: assert property (p_step) else $error("step");
    property p_win; s_cw |=> counterValue == $past(pwdata[7:0]); endproperty
    a_win: assert property (p_win) else $error("win");
    property p_hold; !clkEn |=> $stable(counterValue); endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_ack; overflowIrqAck && clkEn ##1 counterValue != 8'h00 |-> !irqOut; endproperty
    a_ack: assert property (p_ack) else $error("ack");
    property p_w1c; s_fc |-> !irqOut; endproperty
    a_w1c: assert property (p_w1c) else $error("w1c");
    property p_rise; $rose(irqOut) |-> $rose(globalIrqEnable) || counterValue == 8'h00 || $past(wr);
    endproperty
    a_rise: assert property (p_rise) else $error("rise");
    property p_read; psel && penable && !pwrite && clkEn && !pready && paddr == COUNTER_VALUE_ADDR |=>
        prdata == {24'h000000, $past(counterValue)}; endproperty
    a_read: assert property (p_read) else $error("read");
endmodule // ovf_timer_monitor
bind eight_bit_overflow_timer ovf_timer_monitor ovf_timer_monitor_i (.ref_clk(ref_clk),
    .arst_n(arst_n), .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .overflowIrqAck(overflowIrqAck), .irqOut(irqOut),
    .globalIrqEnable(globalIrqEnable), .paddr(paddr), .counterValue(counterValue),
    .pwdata(pwdata), .prdata(prdata));
`default_nettype wire

// ==== verilog/eight_bit_overflow_timer.sv ====
// 8-bit overflow timer with APB register access and interrupt output
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module eight_bit_overflow_timer
    import ovf_timer_pkg::*;
#(
    parameter int PRESCALER_WIDTH = PRESC_W
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic externalCountPin,
    input wire logic globalIrqEnable,
    input wire logic overflowIrqAck,
    input wire logic [7:0] otherFlagSet,
    output logic irqOut,
    output logic [7:0] counterValue,
    output logic [PRESCALER_WIDTH-1:0] prescalerTaps
);

    // Register state and next values
    logic [7:0] timerControl_ff;
    logic [7:0] nxt_timerControl;
    logic [7:0] counter_ff;
    logic [7:0] nxt_counter;
    logic [7:0] irqMask_ff;
    logic [7:0] nxt_irqMask;
    logic [7:0] irqFlags_ff;
    logic [7:0] nxt_irqFlags;
    logic [PRESCALER_WIDTH-1:0] presc_ff;
    logic [PRESCALER_WIDTH-1:0] nxt_presc;

    // Pin synchroniser and edge history
    logic pinMeta_ff;
    logic nxt_pinMeta;
    logic pinSync_ff;
    logic nxt_pinSync;
    logic pinPrev_ff;
    logic nxt_pinPrev;

    // Read path
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic rdValid_ff;
    logic nxt_rdValid;

    // Bus decode
    logic apbAccess;
    logic apbWrite;
    logic apbRead;
    logic addrOk;
    logic selControl;
    logic selCounter;
    logic selMask;
    logic selFlags;
    logic selPresc;
    logic wrControl;
    logic wrCounter;
    logic wrMask;
    logic wrFlags;
    logic prescReset;
    logic readPending;

    // Tick generation
    logic [2:0] tickSourceSelect;
    logic tapDiv8;
    logic tapDiv64;
    logic tapDiv256;
    logic tapDiv1024;
    logic pinRise;
    logic pinFall;
    logic timerTick;
    logic wrapTick;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    assign apbAccess = psel && penable;
    assign apbWrite = apbAccess && pwrite;
    assign apbRead = apbAccess && !pwrite;

    assign selControl = (paddr == TIMER_CONTROL_ADDR);
    assign selCounter = (paddr == COUNTER_VALUE_ADDR);
    assign selMask = (paddr == TIMER_IRQ_MASK_ADDR);
    assign selFlags = (paddr == TIMER_IRQ_FLAGS_ADDR);
    assign selPresc = (paddr == PRESCALER_CTRL_ADDR);

    assign addrOk = selControl || selCounter || selMask || selFlags || selPresc;

    // Writes only land on an enabled edge, so they are gated like all state
    assign wrControl = apbWrite && clkEn && selControl;
    assign wrCounter = apbWrite && clkEn && selCounter;
    assign wrMask = apbWrite && clkEn && selMask;
    assign wrFlags = apbWrite && clkEn && selFlags;
    assign prescReset = apbWrite && clkEn && selPresc && pwdata[PRESC_RESET_BIT];

    // Reads take one wait state so that read data comes from a flip-flop
    assign readPending = apbRead && !rdValid_ff;

    // A frozen block never completes a transfer, so nothing is lost
    assign pready = clkEn && (!apbRead || rdValid_ff);
    assign pslverr = apbAccess && pready && !addrOk;
    assign prdata = prdata_ff;

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    always_comb begin
        nxt_timerControl = timerControl_ff;
        if (wrControl) begin
            nxt_timerControl = pwdata[7:0];
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            timerControl_ff <= CONTROL_RESET;
        end else if (clkEn) begin
            timerControl_ff <= nxt_timerControl;
        end
    end

    assign tickSourceSelect = timerControl_ff[SEL_LSB +: SEL_W];

    // ------------------------------------------------------------------
    // Interrupt mask register
    // ------------------------------------------------------------------
    always_comb begin
        nxt_irqMask = irqMask_ff;
        if (wrMask) begin
            nxt_irqMask = pwdata[7:0];
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            irqMask_ff <= MASK_RESET;
        end else if (clkEn) begin
            irqMask_ff <= nxt_irqMask;
        end
    end

    // ------------------------------------------------------------------
    // Free-running prescaler, cleared by the prescaler reset bit
    // ------------------------------------------------------------------
    always_comb begin
        nxt_presc = presc_ff + 1'b1;
        if (prescReset) begin
            nxt_presc = '0;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            presc_ff <= '0;
        end else if (clkEn) begin
            presc_ff <= nxt_presc;
        end
    end

    // Each tap is a one-cycle pulse when its low bits are all ones
    assign tapDiv8 = (presc_ff[2:0] == 3'h7);
    assign tapDiv64 = (presc_ff[5:0] == 6'h3F);
    assign tapDiv256 = (presc_ff[7:0] == 8'hFF);
    assign tapDiv1024 = (presc_ff[9:0] == 10'h3FF);

    // ------------------------------------------------------------------
    // External count pin: two-stage synchroniser, then edge history
    // ------------------------------------------------------------------
    always_comb begin
        nxt_pinMeta = externalCountPin;
        nxt_pinSync = pinMeta_ff;
        nxt_pinPrev = pinSync_ff;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pinMeta_ff <= 1'b0;
            pinSync_ff <= 1'b0;
            pinPrev_ff <= 1'b0;
        end else if (clkEn) begin
            pinMeta_ff <= nxt_pinMeta;
            pinSync_ff <= nxt_pinSync;
            pinPrev_ff <= nxt_pinPrev;
        end
    end

    // Edges come from the synchronised level, whatever drives the pin
    assign pinRise = !pinPrev_ff && pinSync_ff;
    assign pinFall = pinPrev_ff && !pinSync_ff;

    // ------------------------------------------------------------------
    // Tick source selection
    // ------------------------------------------------------------------
    always_comb begin
        timerTick = 1'b0;
        case (tickSourceSelect)
            SEL_STOP: begin
                timerTick = 1'b0;
            end
            SEL_DIV1: begin
                timerTick = 1'b1;
            end
            SEL_DIV8: begin
                timerTick = tapDiv8;
            end
            SEL_DIV64: begin
                timerTick = tapDiv64;
            end
            SEL_DIV256: begin
                timerTick = tapDiv256;
            end
            SEL_DIV1024: begin
                timerTick = tapDiv1024;
            end
            SEL_EXT_FALL: begin
                timerTick = pinFall;
            end
            SEL_EXT_RISE: begin
                timerTick = pinRise;
            end
            default: begin
                timerTick = 1'b0;
            end
        endcase
    end

    assign wrapTick = timerTick && (counter_ff == COUNT_MAX);

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    always_comb begin
        nxt_counter = counter_ff;
        if (timerTick) begin
            nxt_counter = counter_ff + 8'h01;
        end
        if (wrCounter) begin
            nxt_counter = pwdata[7:0];
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            counter_ff <= COUNTER_RESET;
        end else if (clkEn) begin
            counter_ff <= nxt_counter;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt flags; any set wins over a same-cycle clear
    // ------------------------------------------------------------------
    always_comb begin
        nxt_irqFlags = irqFlags_ff;
        if (wrFlags) begin
            nxt_irqFlags = irqFlags_ff & ~pwdata[7:0];
        end
        if (overflowIrqAck) begin
            nxt_irqFlags[OVF_BIT] = 1'b0;
        end
        nxt_irqFlags = nxt_irqFlags | otherFlagSet;
        if (wrapTick) begin
            nxt_irqFlags[OVF_BIT] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            irqFlags_ff <= FLAGS_RESET;
        end else if (clkEn) begin
            irqFlags_ff <= nxt_irqFlags;
        end
    end

    // ------------------------------------------------------------------
    // Read data, captured in the first access cycle
    // ------------------------------------------------------------------
    always_comb begin
        nxt_rdValid = 1'b0;
        nxt_prdata = prdata_ff;
        if (readPending) begin
            nxt_rdValid = 1'b1;
            case (paddr)
                TIMER_CONTROL_ADDR: begin
                    nxt_prdata = {24'h000000, timerControl_ff};
                end
                COUNTER_VALUE_ADDR: begin
                    nxt_prdata = {24'h000000, counter_ff};
                end
                TIMER_IRQ_MASK_ADDR: begin
                    nxt_prdata = {24'h000000, irqMask_ff};
                end
                TIMER_IRQ_FLAGS_ADDR: begin
                    nxt_prdata = {24'h000000, irqFlags_ff};
                end
                default: begin
                    nxt_prdata = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata_ff <= 32'h00000000;
            rdValid_ff <= 1'b0;
        end else if (clkEn) begin
            prdata_ff <= nxt_prdata;
            rdValid_ff <= nxt_rdValid;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign irqOut = irqFlags_ff[OVF_BIT] && irqMask_ff[OVF_BIT] && globalIrqEnable;
    assign counterValue = counter_ff;
    assign prescalerTaps = presc_ff;

endmodule // eight_bit_overflow_timer
`default_nettype wire
